/* dils_pkg.sv */
/*
 * Shared constants for the system-side init and link-enable sequencer and its host.
 * Assumes one 125 MHz clock and a synchronous active-low reset in both ends.
 */
package dils_pkg;
    // register numbers of the device map
    localparam logic [7:0] DILS_REG_POWER = 8'h06;
    localparam logic [7:0] DILS_REG_LINE16 = 8'h10;
    localparam logic [7:0] DILS_REG_LINE26 = 8'h1a;
    localparam logic [7:0] DILS_REG_ACIM30 = 8'h1e;
    localparam logic [7:0] DILS_REG_OHS31 = 8'h1f;
    localparam logic [7:0] DILS_REG_PCM33 = 8'h21;
    localparam logic [7:0] DILS_REG_GCI42 = 8'h2a;
    localparam logic [7:0] DILS_REG_TXG38 = 8'h26;
    localparam logic [7:0] DILS_REG_FS31B = 8'h1f;
    localparam logic [7:0] DILS_REG_NUM = 8'h40;
    // field positions in the power register
    localparam int DILS_BIT_SYS_PD = 3;
    localparam int DILS_BIT_LINE_PD = 4;
    localparam logic [7:0] DILS_POWER_RESET = 8'h10; // line side down, system up
    localparam logic [7:0] DILS_POWER_UP = 8'h00;
    // mode enable values
    localparam logic [7:0] DILS_PCM_ENABLE = 8'h20;
    localparam logic [7:0] DILS_GCI_ENABLE = 8'h01;
    // harmonised european profile: current_limit_sel=1 dcv=11 mini=00 (reg 26), acim=0010, ohs/rz/rt=0
    localparam logic [7:0] DILS_EU_LINE16 = 8'h00;
    localparam logic [7:0] DILS_EU_LINE26 = 8'hc2;
    localparam logic [7:0] DILS_EU_ACIM30 = 8'h02;
    // north american profile
    localparam logic [7:0] DILS_US_LINE16 = 8'h00;
    localparam logic [7:0] DILS_US_LINE26 = 8'hc0;
    localparam logic [7:0] DILS_US_ACIM30 = 8'h00;
    localparam logic [7:0] DILS_TXG_DEFAULT = 8'h00;
    localparam logic [7:0] DILS_FS_IIR = 8'h10; // full scale alt + iir enable as chosen
    // pll lock time, kept well under the 1 ms bound, counted at 125 MHz
    localparam int DILS_CLK_MHZ = 125;
    localparam int DILS_LOCK_US = 100;
    localparam int DILS_LOCK_CYC = DILS_LOCK_US * DILS_CLK_MHZ;
    localparam int DILS_LOCK_W = 17;
    // host step order
    typedef enum {
        DILS_H_RESET, DILS_H_WAIT_LOCK, DILS_H_MODE, DILS_H_L16, DILS_H_L26,
        DILS_H_ACIM, DILS_H_TXG, DILS_H_FS, DILS_H_POWER, DILS_H_DONE
    } dils_host_e;
endpackage : dils_pkg

/* dils_if.sv */
/*
 * Connection between the host and the system-side sequencer.
 * Assumes both parties share clk; writes are single-cycle strobes.
 */
`timescale 1ns/1ps
interface dils_if;
    logic dev_reset_n;     // hardware reset pin from host
    logic wr_en;           // one-cycle register write strobe
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic pll_locked;      // device lock flag
    logic link_enabled;    // device link state
    logic ring_detect;     // ring status from link
    modport device (input dev_reset_n, input wr_en, input wr_addr, input wr_data,
                    output pll_locked, output link_enabled, output ring_detect);
    modport host (output dev_reset_n, output wr_en, output wr_addr, output wr_data,
                  input pll_locked, input link_enabled, input ring_detect);
endinterface : dils_if

/* dils_device.sv */
/*
 * System-side power-up sequencer of the voice line interface chipset.
 * Holds the register defaults that keep the line side powered down after
 * any reset, the pll lock timer that runs from the pcm bit clock and the
 * frame sync, the enable of the isolation link and the paths across it.
 * The link opens only when the host has cleared the line powerdown bit and
 * the pll is locked; while it is shut outside reset the transmit sample is looped back to
 * the receive output and no sample, control, ring or caller id data crosses.
 * Setting both powerdown bits latches full powerdown, in which writes are
 * ignored and ring status stays low until the next reset.
 * The lock time is a package constant counted in clk cycles; a gap in the
 * bit clock drops lock and restarts the count.
 * Every output is taken straight from the state register.
 * Assumes pcm clock presence and frame sync arrive as levels already
 * synchronous to clk, a host on dils_if that writes one register per
 * strobe, and a synchronous active-low system reset; the device reset pin
 * from the host acts as a second synchronous reset.
 */
`timescale 1ns/1ps
module dils_device
    import dils_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic reset_n,
    // host side
    dils_if.device bus,
    // pcm highway and line-side data
    input wire logic pcm_clk_present,
    input wire logic pcm_frame_sync,
    input wire logic [15:0] tx_sample,
    input wire logic [15:0] line_rx_sample,
    input wire logic line_ring,
    input wire logic [7:0] line_cid,
    // link outputs
    output logic [15:0] link_tx_sample,
    output logic [15:0] rx_sample,
    output logic [7:0] link_ctrl,
    output logic [7:0] cid_data,
    output logic line_side_powerdown,
    output logic system_powerdown,
    output logic full_powerdown,
    output logic [7:0] mode_reg,
    output logic [7:0] line_cfg
);
    // whole state in one record: the always_comb fills a copy,
    // the always_ff registers it
    typedef struct packed {
        logic [7:0] power; // powerdown register, bits 3 and 4 used
        logic [7:0] pcm; // pcm highway mode register
        logic [7:0] gci; // gci mode register
        logic [7:0] mode; // registered union of the mode enables
        logic [7:0] line26; // current limit, dc termination, minimum current
        logic fs_d; // frame sync one clock late
        logic [DILS_LOCK_W-1:0] lock_cnt;
        logic frame_seen;
        logic locked;
        logic link_on;
        logic ring;
        logic [15:0] tx_out;
        logic [15:0] rx_out;
        logic [7:0] ctrl;
        logic [7:0] cid;
        logic full_pd;
    } dils_dev_s;

    // state register and its next value
    dils_dev_s st_r;
    dils_dev_s st_nxt;

    // helper decodes feeding the next-state logic
    logic rst_active; // either reset source is active
    logic wr_ok; // host write that is allowed to land
    logic fs_rise; // start of a frame sync pulse
    logic lock_end; // lock timer at its last count
    logic line_up; // line powerdown bit cleared
    logic pass_en; // data may cross the link

    // the device pin reset and the system reset both restart the sequence;
    // either one returns every register to the line-side-down defaults
    assign rst_active = !reset_n || !bus.dev_reset_n;

    // writes are dropped while full powerdown is latched
    assign wr_ok = bus.wr_en && !st_r.full_pd;

    // a frame sync counts once per pulse, however long it is held
    assign fs_rise = pcm_frame_sync && !st_r.fs_d;

    // last count of the lock timer
    assign lock_end = st_r.lock_cnt == DILS_LOCK_W'(DILS_LOCK_CYC - 1);

    // host has cleared the line powerdown bit
    assign line_up = !st_r.power[DILS_BIT_LINE_PD];

    // data crosses only while the link is up and full powerdown is clear
    assign pass_en = st_r.link_on && !st_r.full_pd;

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        if (rst_active) begin
            // reset operation: line side down, system side up, link off
            st_nxt = '0;
            st_nxt.power = DILS_POWER_RESET;
            st_nxt.line26 = DILS_US_LINE26;
        end else begin
            // register writes from the host; numbers not held here are ignored,
            // and a power register write shows on the next edge
            if (wr_ok) begin
                unique case (bus.wr_addr)
                    DILS_REG_POWER: st_nxt.power = bus.wr_data;
                    DILS_REG_PCM33: st_nxt.pcm = bus.wr_data;
                    DILS_REG_GCI42: st_nxt.gci = bus.wr_data;
                    DILS_REG_LINE26: st_nxt.line26 = bus.wr_data;
                    default: st_nxt.power = st_r.power;
                endcase
            end

            // one 8-bit register carries the union of both mode enables
            st_nxt.mode = st_nxt.pcm | st_nxt.gci;

            // frame sync delay for the edge detect
            st_nxt.fs_d = pcm_frame_sync;

            // lock needs the bit clock for the lock time and one frame sync;
            // the counter stops at its last value so lock holds while the clock runs
            if (pcm_clk_present) begin
                if (fs_rise) begin
                    st_nxt.frame_seen = 1'b1;
                end
                if (!lock_end) begin
                    st_nxt.lock_cnt = st_r.lock_cnt + DILS_LOCK_W'(1);
                end else if (st_r.frame_seen) begin
                    st_nxt.locked = 1'b1;
                end
            end else begin
                // losing the bit clock drops lock and restarts the timer
                st_nxt.lock_cnt = '0;
                st_nxt.locked = 1'b0;
                st_nxt.frame_seen = 1'b0;
            end

            // link only with line side up and pll locked; checking lock too
            // keeps an early power-up write from opening an unlocked link
            st_nxt.link_on = line_up && st_r.locked;

            // both powerdown bits latch full powerdown; only a reset clears it
            if (st_r.power[DILS_BIT_LINE_PD] && st_r.power[DILS_BIT_SYS_PD]) begin
                st_nxt.full_pd = 1'b1;
            end

            // samples, control, ring status and caller id cross the link
            if (pass_en) begin
                st_nxt.tx_out = tx_sample;
                st_nxt.rx_out = line_rx_sample;
                st_nxt.ctrl = st_r.line26;
                st_nxt.ring = line_ring;
                st_nxt.cid = line_cid;
            end else begin
                // link shut: nothing crosses, transmit loops back to receive
                st_nxt.tx_out = '0;
                st_nxt.rx_out = tx_sample;
                st_nxt.ctrl = '0;
                st_nxt.ring = 1'b0;
                st_nxt.cid = '0;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // status back to the host
    assign bus.pll_locked = st_r.locked;
    assign bus.link_enabled = st_r.link_on;
    assign bus.ring_detect = st_r.ring;

    // data paths across the link
    assign link_tx_sample = st_r.tx_out;
    assign rx_sample = st_r.rx_out;
    assign link_ctrl = st_r.ctrl;
    assign cid_data = st_r.cid;

    // power and configuration view
    assign line_side_powerdown = st_r.power[DILS_BIT_LINE_PD];
    assign system_powerdown = st_r.power[DILS_BIT_SYS_PD];
    assign full_powerdown = st_r.full_pd;
    assign mode_reg = st_r.mode;
    assign line_cfg = st_r.line26;
endmodule : dils_device

/* dils_host.sv */
/*
 * Host-side initialisation sequencer for the system-side device.
 * Assumes the device answers over dils_if on the same clock.
 */
`timescale 1ns/1ps
module dils_host
    import dils_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic reset_n,
    // user control
    input wire logic start,
    input wire logic use_gci,
    input wire logic profile_eu,
    // status
    output logic init_done,
    output logic busy,
    // device side
    dils_if.host bus
);
    typedef struct packed {
        dils_host_e step;
        logic rst_pin_n;
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic done;
        logic busy; // registered so the status output comes from a flop
    } dils_host_s;

    dils_host_s st_r;
    dils_host_s st_nxt;

    // one write per step from mode to power, in the documented order
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr = 1'b0;
        if (!reset_n) begin
            st_nxt = '0;
            st_nxt.step = DILS_H_RESET;
        end else begin
            unique case (st_r.step)
                DILS_H_RESET: begin
                    st_nxt.rst_pin_n = 1'b0;
                    if (start) begin
                        st_nxt.done = 1'b0;
                        st_nxt.step = DILS_H_WAIT_LOCK;
                    end
                end
                DILS_H_WAIT_LOCK: begin
                    st_nxt.rst_pin_n = 1'b1;
                    if (bus.pll_locked && st_r.rst_pin_n)
                        st_nxt.step = DILS_H_MODE;
                end
                DILS_H_MODE: begin
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = use_gci ? DILS_REG_GCI42 : DILS_REG_PCM33;
                    st_nxt.data = use_gci ? DILS_GCI_ENABLE : DILS_PCM_ENABLE;
                    st_nxt.step = DILS_H_L16;
                end
                DILS_H_L16: begin
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = DILS_REG_LINE16;
                    st_nxt.data = profile_eu ? DILS_EU_LINE16 : DILS_US_LINE16;
                    st_nxt.step = DILS_H_L26;
                end
                DILS_H_L26: begin
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = DILS_REG_LINE26;
                    st_nxt.data = profile_eu ? DILS_EU_LINE26 : DILS_US_LINE26;
                    st_nxt.step = DILS_H_ACIM;
                end
                DILS_H_ACIM: begin
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = DILS_REG_ACIM30;
                    st_nxt.data = profile_eu ? DILS_EU_ACIM30 : DILS_US_ACIM30;
                    st_nxt.step = DILS_H_TXG;
                end
                DILS_H_TXG: begin
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = DILS_REG_TXG38;
                    st_nxt.data = DILS_TXG_DEFAULT;
                    st_nxt.step = DILS_H_FS;
                end
                DILS_H_FS: begin
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = DILS_REG_FS31B;
                    st_nxt.data = DILS_FS_IIR;
                    st_nxt.step = DILS_H_POWER;
                end
                DILS_H_POWER: begin
                    st_nxt.wr = 1'b1;
                    st_nxt.addr = DILS_REG_POWER;
                    st_nxt.data = DILS_POWER_UP;
                    st_nxt.step = DILS_H_DONE;
                end
                DILS_H_DONE: begin
                    st_nxt.done = 1'b1;
                    if (start)
                        st_nxt.step = DILS_H_RESET;
                end
            endcase
        end
        // busy whenever a sequence is under way
        st_nxt.busy = (st_nxt.step != DILS_H_RESET) && (st_nxt.step != DILS_H_DONE);
    end

    // state register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign bus.dev_reset_n = st_r.rst_pin_n;
    assign bus.wr_en = st_r.wr;
    assign bus.wr_addr = st_r.addr;
    assign bus.wr_data = st_r.data;
    assign init_done = st_r.done;
    assign busy = st_r.busy;
endmodule : dils_host

/* dils_checker_sva.sv */
/*
 * Concurrent checks on the host/device connection of the init and link-enable sequencer.
 * Assumes it is instantiated beside the interface, on the shared clk and reset_n.
 */
`timescale 1ns/1ps
module dils_checker_sva
    import dils_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // connection signals
    input wire logic dev_reset_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic pll_locked,
    input wire logic link_enabled,
    input wire logic ring_detect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // write steps of the host sequence
    sequence s_power_on;
        wr_en && wr_addr == DILS_REG_POWER && wr_data == DILS_POWER_UP && pll_locked && dev_reset_n;
    endsequence
    sequence s_mode_write;
        wr_en && (wr_addr == DILS_REG_PCM33 || wr_addr == DILS_REG_GCI42);
    endsequence
    property p_pin_off;
        !dev_reset_n |=> !link_enabled && !pll_locked;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("link or lock up while reset pin low");
    property p_pin_held;
        $rose(reset_n) |-> !dev_reset_n;
    endproperty
    a_pin_held: assert property (p_pin_held) else $error("reset pin not held after reset");
    property p_power_on;
        s_power_on |-> ##2 link_enabled;
    endproperty
    a_power_on: assert property (p_power_on) else $error("link not up two cycles after power write");
    property p_mode_then_line;
        s_mode_write |=> wr_en && wr_addr == DILS_REG_LINE16;
    endproperty
    a_mode_then_line: assert property (p_mode_then_line) else $error("line fields not after mode");
    property p_write_locked;
        wr_en |-> pll_locked && dev_reset_n;
    endproperty
    a_write_locked: assert property (p_write_locked) else $error("write before lock");
    property p_last_write;
        s_power_on |=> (!wr_en) [*8];
    endproperty
    a_last_write: assert property (p_last_write) else $error("write after power-up write");
    property p_link_lock;
        $rose(link_enabled) |-> pll_locked;
    endproperty
    a_link_lock: assert property (p_link_lock) else $error("link up without lock");
    property p_ring_gate;
        !link_enabled && !$past(link_enabled) |-> !ring_detect;
    endproperty
    a_ring_gate: assert property (p_ring_gate) else $error("ring status while link off");
endmodule : dils_checker_sva

/* daa_init_link_enable_sequencer_tb_top.sv */
/*
 * Testbench: host and device joined by the interface, two init runs (pcm/eu, gci/us).
 * Assumes the package lock count, well under 1 ms, so each run lasts a little over the lock time.
 */
`timescale 1ns/1ps
module daa_init_link_enable_sequencer_tb_top;
    import dils_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, start = 1'b0, use_gci = 1'b0, profile_eu = 1'b1;
    logic pcm_clk_present = 1'b1, pcm_frame_sync = 1'b0, line_ring = 1'b1;
    logic [15:0] tx_sample = 16'h1234, line_rx_sample = 16'h5a5a, link_tx_sample, rx_sample;
    logic [7:0] line_cid = 8'h3c, link_ctrl, cid_data, mode_reg, line_cfg, fcnt = 8'h00;
    logic line_side_powerdown, system_powerdown, full_powerdown, init_done, busy;
    int errors = 0, n_checks = 0, cyc;
    bit timed_out = 1'b0;
    dils_if i_dils_if();
    dils_device i_dils_device(.clk(clk), .reset_n(reset_n), .bus(i_dils_if.device),
        .pcm_clk_present(pcm_clk_present), .pcm_frame_sync(pcm_frame_sync), .tx_sample(tx_sample),
        .line_rx_sample(line_rx_sample), .line_ring(line_ring), .line_cid(line_cid),
        .link_tx_sample(link_tx_sample), .rx_sample(rx_sample), .link_ctrl(link_ctrl), .cid_data(cid_data),
        .line_side_powerdown(line_side_powerdown), .system_powerdown(system_powerdown),
        .full_powerdown(full_powerdown), .mode_reg(mode_reg), .line_cfg(line_cfg));
    dils_host i_dils_host(.clk(clk), .reset_n(reset_n), .start(start), .use_gci(use_gci),
        .profile_eu(profile_eu), .init_done(init_done), .busy(busy), .bus(i_dils_if.host));
    dils_checker_sva i_dils_checker_sva(.clk(clk), .reset_n(reset_n), .dev_reset_n(i_dils_if.dev_reset_n),
        .wr_en(i_dils_if.wr_en), .wr_addr(i_dils_if.wr_addr), .wr_data(i_dils_if.wr_data),
        .pll_locked(i_dils_if.pll_locked), .link_enabled(i_dils_if.link_enabled),
        .ring_detect(i_dils_if.ring_detect));
    // clock
    initial begin
        forever #4 clk = ~clk;
    end
    // frame sync pulse every 32 clk cycles
    always @(posedge clk) begin
        #1;
        fcnt = fcnt + 8'h01;
        pcm_frame_sync = (fcnt[4:0] == 5'h00);
    end
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // bounded wait for lock (sel 0) or init done (sel 1); a timeout counts a mismatch
    task automatic wait_flag(input bit sel, input int limit);
        for (cyc = 0; cyc < limit && (sel ? init_done : i_dils_if.pll_locked) !== 1'b1; cyc++) begin
            @(posedge clk);
            #1;
        end
        if ((sel ? init_done : i_dils_if.pll_locked) !== 1'b1) begin
            errors++;
            timed_out = 1'b1;
            $display("CHECK FAILED at %0t: timeout", $time);
        end
    endtask : wait_flag
    // two runs: pcm with eu profile, then gci with us profile
    initial begin
        for (int t = 0; t < 2; t++) begin
            @(posedge clk);
            #1;
            reset_n = 1'b0;
            use_gci = (t == 1);
            profile_eu = (t == 0);
            tx_sample = 16'h1234 + 16'(t);
            repeat (16) @(posedge clk);
            #1;
            reset_n = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            check(line_side_powerdown, 1);
            check(system_powerdown, 0);
            check(i_dils_if.link_enabled, 0);
            check(i_dils_if.ring_detect, 0);
            check({i_dils_if.dev_reset_n, busy, init_done}, 0);
            start = 1'b1;
            @(posedge clk);
            #1;
            start = 1'b0;
            wait_flag(1'b0, DILS_LOCK_CYC + 200);
            if (timed_out)
                break;
            check(i_dils_if.link_enabled, 0);
            check(rx_sample, tx_sample);
            check(busy, 1);
            wait_flag(1'b1, 64);
            if (timed_out)
                break;
            repeat (4) @(posedge clk);
            #1;
            check(mode_reg, t == 1 ? DILS_GCI_ENABLE : DILS_PCM_ENABLE);
            check(line_cfg, t == 0 ? DILS_EU_LINE26 : DILS_US_LINE26);
            check({line_side_powerdown, system_powerdown, full_powerdown}, 0);
            check(i_dils_if.link_enabled, 1);
            check(i_dils_if.ring_detect, 1);
            check({rx_sample, cid_data}, {line_rx_sample, line_cid});
            check(link_tx_sample, tx_sample);
            check(link_ctrl, t == 0 ? DILS_EU_LINE26 : DILS_US_LINE26);
            check(busy, 0);
            // bit clock lost: lock drops and the link shuts with nothing crossing
            pcm_clk_present = 1'b0;
            repeat (3) @(posedge clk);
            #1;
            check(i_dils_if.pll_locked, 0);
            check({i_dils_if.link_enabled, i_dils_if.ring_detect}, 0);
            check({link_tx_sample, link_ctrl, cid_data}, 0);
            pcm_clk_present = 1'b1;
            $display("test %0d done", t);
        end
        print_verdict();
    end
endmodule : daa_init_link_enable_sequencer_tb_top
